// ===== resp_pkg.sv
package resp_pkg;

  // response formats the card can send
  typedef enum logic [2:0] {
    kind_normal,
    kind_busy,
    kind_long,
    kind_ocr,
    kind_rca,
    kind_ifcond
  } resp_kind_t;

  // card states touched by the operating-condition command
  typedef enum logic [1:0] {
    st_idle,
    st_ready,
    st_inactive
  } card_state_t;

  // frame geometry
  localparam int FRAME_W = 136;
  localparam logic [7:0] SHORT_LAST = 8'h2f; // 48 bits, msb index 47
  localparam logic [7:0] LONG_LAST = 8'h87; // 136 bits, msb index 135
  localparam logic [7:0] CRC_HI = 8'h07;
  localparam logic [7:0] CRC_LO = 8'h01;
  localparam logic [7:0] BODY_LO = 8'h08;

  // fixed field values
  localparam logic [1:0] START_DIR = 2'h0; // start bit, card-to-host bit
  localparam logic END_BIT = 1'b1;
  localparam logic [5:0] IDX_ONES = 6'h3f;
  localparam logic [5:0] IDX_RCA = 6'h03;
  localparam logic [5:0] IDX_IFCOND = 6'h08;
  localparam logic [5:0] IDX_CSD = 6'h09;
  localparam logic [6:0] CRC_ONES = 7'h7f;
  localparam logic [19:0] IFCOND_RSVD = 20'h00000;
  localparam logic [87:0] SHORT_PAD = 88'h0;

  // crc7 generator x^7 + x^3 + 1
  localparam logic [6:0] CRC_POLY = 7'h09;
  localparam logic [6:0] CRC_INIT = 7'h00;

endpackage : resp_pkg

// ===== crc_if.sv
`timescale 1ns/1ns
// control and result of the serial crc7 engine
interface crc_if;
  logic clr;
  logic en;
  logic shf;
  logic din;
  logic [6:0] crc;

  modport src (output clr, output en, output shf, output din, input crc);
  modport eng (input clr, input en, input shf, input din, output crc);
endinterface : crc_if

// ===== crc7_serial.sv
`timescale 1ns/1ns
// bit-serial crc7, also shifts its result out msb first
module crc7_serial (
  input wire logic link_clk,
  input wire logic rst_b,
  crc_if.eng c
);
  import resp_pkg::*;

  logic [6:0] crc_r;
  logic [6:0] crc_nxt;
  logic [6:0] base;
  logic fb;

  // clear restarts from zero and may feed the first bit at once
  always_comb begin
    base = c.clr ? CRC_INIT : crc_r;
    fb = c.din ^ base[6];
    crc_nxt = base;
    if (c.en) begin
      crc_nxt = {base[5:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
    end else if (c.shf) begin
      crc_nxt = {base[5:0], 1'b0};
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      crc_r <= CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign c.crc = crc_r;

endmodule : crc7_serial

// ===== resp_framer.sv
`timescale 1ns/1ns
// Behaviour
// - op-condition command: ready, idle or inactive
// - responses go out msb first on command line
// - start bit zero, then direction bit zero
// - crc7 on all short responses except ocr response
// - every response ends with a one
// - normal response: 48 bits, index, status, crc
// - card may hold data line busy after blocks
// - busy response is normal plus optional busy
// - long response: 136 bits, ones, register 127:1
// - identification or card-specific register by index
// - ocr response: ones index, ocr, ones crc
// - address response: index 3, rca, status bits
// - interface response: index 8, voltage, pattern
module resp_framer (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic resp_req,
  input wire resp_pkg::resp_kind_t resp_kind,
  input wire logic [5:0] resp_index,
  input wire logic [31:0] resp_arg,
  input wire logic [31:0] card_status,
  input wire logic [15:0] rca,
  input wire logic [3:0] volt_acc,
  input wire logic [7:0] check_pat,
  input wire logic [127:1] cid,
  input wire logic [127:1] csd,
  input wire logic acmd41_req,
  input wire logic vdd_ok,
  input wire logic init_busy,
  input wire logic prog_busy,
  output logic resp_ready,
  output resp_pkg::card_state_t card_state,
  output logic cmd_out,
  output logic cmd_oe,
  output logic dat0_out,
  output logic dat0_oe
);
  import resp_pkg::*;

  // ref_clk domain
  logic [FRAME_W-1:0] frame_r;
  logic [FRAME_W-1:0] frame_nxt;
  logic long_r;
  logic long_nxt;
  logic crc_on_r;
  logic crc_on_nxt;
  logic req_tgl_r;
  logic req_tgl_nxt;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ready_r;
  logic ready_nxt;
  card_state_t state_r;
  card_state_t state_nxt;
  logic accept;
  logic [5:0] idx;
  logic [31:0] body;
  logic crc_want;

  // link_clk domain
  logic [FRAME_W-1:0] sh_r;
  logic [FRAME_W-1:0] sh_nxt;
  logic [7:0] pos_r;
  logic [7:0] pos_nxt;
  logic tx_on_r;
  logic tx_on_nxt;
  logic crcm_r;
  logic crcm_nxt;
  logic lng_r;
  logic lng_nxt;
  logic rq_s1_r;
  logic rq_s2_r;
  logic seen_r;
  logic seen_nxt;
  logic ack_tgl_r;
  logic ack_tgl_nxt;
  logic out_r;
  logic out_nxt;
  logic oe_r;
  logic oe_nxt;
  logic bsy_s1_r;
  logic bsy_s2_r;
  logic d_oe_r;
  logic d_out_r;
  logic start;

  crc_if cif ();

  crc7_serial crc7_serial_inst (
    .link_clk(link_clk),
    .rst_b(rst_b),
    .c(cif.eng)
  );

  // field selection per response format
  always_comb begin
    idx = resp_index;
    body = resp_arg;
    crc_want = 1'b1;
    case (resp_kind)
      kind_normal, kind_busy: begin
        idx = resp_index;
        body = card_status;
      end
      kind_ocr: begin
        idx = IDX_ONES;
        body = resp_arg;
        crc_want = 1'b0;
      end
      kind_rca: begin
        idx = IDX_RCA;
        body = {rca, card_status[23], card_status[22], card_status[19],
                card_status[12:0]};
      end
      kind_ifcond: begin
        idx = IDX_IFCOND;
        body = {IFCOND_RSVD, volt_acc, check_pat};
      end
      default: begin
        idx = IDX_ONES;
        body = resp_arg;
      end
    endcase
  end

  // request capture and handshake toward the link side
  always_comb begin
    accept = resp_req && ready_r;
    frame_nxt = frame_r;
    long_nxt = long_r;
    crc_on_nxt = crc_on_r;
    req_tgl_nxt = req_tgl_r;
    if (accept) begin
      req_tgl_nxt = !req_tgl_r;
      if (resp_kind == kind_long) begin
        long_nxt = 1'b1;
        crc_on_nxt = 1'b0;
        frame_nxt = (resp_index == IDX_CSD) ?
                    {START_DIR, IDX_ONES, csd, END_BIT} :
                    {START_DIR, IDX_ONES, cid, END_BIT};
      end else begin
        long_nxt = 1'b0;
        crc_on_nxt = crc_want;
        frame_nxt = {START_DIR, idx, body, CRC_ONES, END_BIT,
                     SHORT_PAD};
      end
    end
    ready_nxt = !(accept || (req_tgl_nxt != ack_s2_r));
  end

  // operating-condition command outcome from idle
  always_comb begin
    state_nxt = state_r;
    if (acmd41_req && state_r == st_idle) begin
      if (!vdd_ok) begin
        state_nxt = st_inactive;
      end else if (init_busy) begin
        state_nxt = st_idle;
      end else begin
        state_nxt = st_ready;
      end
    end
  end

  // ref_clk registers, ack toggle synchroniser
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_r <= '0;
      long_r <= 1'b0;
      crc_on_r <= 1'b0;
      req_tgl_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ready_r <= 1'b0;
      state_r <= st_idle;
    end else begin
      frame_r <= frame_nxt;
      long_r <= long_nxt;
      crc_on_r <= crc_on_nxt;
      req_tgl_r <= req_tgl_nxt;
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ready_r <= ready_nxt;
      state_r <= state_nxt;
    end
  end

  // serialiser: frame_r is stable while the request toggle is pending
  always_comb begin
    start = (rq_s2_r != seen_r) && !tx_on_r;
    sh_nxt = sh_r;
    pos_nxt = pos_r;
    tx_on_nxt = tx_on_r;
    crcm_nxt = crcm_r;
    lng_nxt = lng_r;
    seen_nxt = seen_r;
    ack_tgl_nxt = ack_tgl_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    cif.clr = 1'b0;
    cif.en = 1'b0;
    cif.shf = 1'b0;
    cif.din = 1'b0;
    if (start) begin
      seen_nxt = rq_s2_r;
      sh_nxt = frame_r;
      pos_nxt = long_r ? LONG_LAST : SHORT_LAST;
      lng_nxt = long_r;
      crcm_nxt = crc_on_r;
      tx_on_nxt = 1'b1;
      out_nxt = frame_r[FRAME_W-1];
      oe_nxt = 1'b1;
      cif.clr = 1'b1;
      cif.en = 1'b1;
      cif.din = frame_r[FRAME_W-1];
    end else if (tx_on_r) begin
      if (pos_r == 8'h00) begin
        tx_on_nxt = 1'b0;
        oe_nxt = 1'b0;
        out_nxt = 1'b1;
        ack_tgl_nxt = seen_r;
      end else begin
        sh_nxt = {sh_r[FRAME_W-2:0], 1'b0};
        pos_nxt = pos_r - 8'h01;
        if (crcm_r && pos_nxt <= CRC_HI && pos_nxt >= CRC_LO) begin
          out_nxt = cif.crc[6];
          cif.shf = 1'b1;
        end else begin
          out_nxt = sh_r[FRAME_W-2];
          cif.en = (pos_nxt >= BODY_LO);
          cif.din = sh_r[FRAME_W-2];
        end
      end
    end
  end

  // link_clk registers and synchronisers
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_r <= '0;
      pos_r <= 8'h00;
      tx_on_r <= 1'b0;
      crcm_r <= 1'b0;
      lng_r <= 1'b0;
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      seen_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      out_r <= 1'b1;
      oe_r <= 1'b0;
      bsy_s1_r <= 1'b0;
      bsy_s2_r <= 1'b0;
      d_oe_r <= 1'b0;
      d_out_r <= 1'b1;
    end else begin
      sh_r <= sh_nxt;
      pos_r <= pos_nxt;
      tx_on_r <= tx_on_nxt;
      crcm_r <= crcm_nxt;
      lng_r <= lng_nxt;
      rq_s1_r <= req_tgl_r;
      rq_s2_r <= rq_s1_r;
      seen_r <= seen_nxt;
      ack_tgl_r <= ack_tgl_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      bsy_s1_r <= prog_busy;
      bsy_s2_r <= bsy_s1_r;
      d_oe_r <= bsy_s2_r;
      d_out_r <= !bsy_s2_r;
    end
  end

  // outputs straight from flip-flops
  assign resp_ready = ready_r;
  assign card_state = state_r;
  assign cmd_out = out_r;
  assign cmd_oe = oe_r;
  assign dat0_out = d_out_r;
  assign dat0_oe = d_oe_r;

  // checks
  logic [7:0] cnt_r;

  // counts driven bits of the current frame
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
    end else if (!oe_r) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  sequence s_head;
    !cmd_out ##1 !cmd_out;
  endsequence

  sequence s_long_ones;
    cmd_out [*6];
  endsequence

  a_start_dir: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    $rose(cmd_oe) |-> s_head)
    else $error("start or direction bit not zero");

  a_end_bit: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    cmd_oe && pos_r == 8'h00 |-> cmd_out ##1 !cmd_oe)
    else $error("frame did not end with a one");

  a_short_len: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    $fell(cmd_oe) && !lng_r |-> $past(cnt_r) == 8'h2f)
    else $error("short frame not 48 bits");

  a_long_len: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    $fell(cmd_oe) && lng_r |-> $past(cnt_r) == 8'h87)
    else $error("long frame not 136 bits");

  a_long_ones: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    $rose(cmd_oe) && lng_r |-> ##2 s_long_ones)
    else $error("long frame reserved field not ones");

  a_ocr_crc_ones: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    cmd_oe && !lng_r && !crcm_r && pos_r <= 8'h07 |-> cmd_out)
    else $error("ocr response crc field not ones");

  a_msb_first: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    cmd_oe && pos_r >= 8'h09 |=> cmd_out == $past(sh_r[FRAME_W-2]))
    else $error("bits not sent msb first");

  a_busy_line: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    bsy_s2_r |=> dat0_oe && !dat0_out)
    else $error("data line not held busy");

  a_busy_free: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    !bsy_s2_r |=> !dat0_oe)
    else $error("data line held without busy");

  a_acmd_inact: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    acmd41_req && card_state == st_idle && !vdd_ok
    |=> card_state == st_inactive)
    else $error("incompatible range did not go inactive");

  a_acmd_ready: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    acmd41_req && card_state == st_idle && vdd_ok && !init_busy
    |=> card_state == st_ready)
    else $error("compatible card did not become ready");

  a_acmd_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    acmd41_req && card_state == st_idle && vdd_ok && init_busy
    |=> card_state == st_idle)
    else $error("busy card left idle");

  a_req_taken: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    resp_req && resp_ready |=> !resp_ready)
    else $error("ready not dropped after request");

endmodule : resp_framer

// ===== host_model.sv
`timescale 1ns/1ns
// host side of the card bus: makes the bus clock, captures frames
module host_model (
  input wire logic run,
  input wire logic cmd_out,
  input wire logic cmd_oe,
  input wire logic dat0_out,
  input wire logic dat0_oe,
  output logic link_clk,
  output logic [135:0] frame_r,
  output logic [7:0] nbits_r,
  output logic dat0_line
);
  logic prev_oe_r;
  logic cmd_line;
  // both lines are pulled up while the card lets go
  assign cmd_line = cmd_oe ? cmd_out : 1'h1;
  assign dat0_line = dat0_oe ? dat0_out : 1'h1;
  // bus clock runs only while asked and parks low between frames
  initial begin
    link_clk = 1'h0;
    #7;
    forever begin
      #40;
      if (run || link_clk) link_clk = ~link_clk;
    end
  end
  // sample mid-bit; the first driven bit restarts the capture
  always @(negedge link_clk) begin
    prev_oe_r <= cmd_oe;
    if (cmd_oe && !prev_oe_r) begin
      frame_r <= {135'h0, cmd_line};
      nbits_r <= 8'h01;
    end else if (cmd_oe) begin
      frame_r <= {frame_r[134:0], cmd_line};
      nbits_r <= nbits_r + 8'h01;
    end
  end
endmodule : host_model

// ===== resp_framer_test.sv
`timescale 1ns/1ns
module resp_framer_test;
  import resp_pkg::*;
  localparam logic [127:1] CID_V = {31'h13572468, 96'h0123456789abcdef01234567};
  localparam logic [127:1] CSD_V = {31'h2468ace0, 96'hfedcba9876543210fedcba98};
  localparam logic [31:0] ST_V = 32'hffb7fa5f;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic run = 1'h1;
  logic resp_req = 1'h0;
  resp_kind_t resp_kind = kind_normal;
  logic [5:0] resp_index = 6'h00;
  logic [31:0] resp_arg = 32'h0;
  logic [31:0] card_status = 32'h0;
  logic [15:0] rca = 16'h0;
  logic [3:0] volt_acc = 4'h0;
  logic [7:0] check_pat = 8'h0;
  logic [127:1] cid = 127'h0;
  logic [127:1] csd = 127'h0;
  logic acmd41_req = 1'h0;
  logic vdd_ok = 1'h1;
  logic init_busy = 1'h0;
  logic prog_busy = 1'h0;
  logic resp_ready, cmd_out, cmd_oe, dat0_out, dat0_oe, link_clk, dat0_line;
  card_state_t card_state;
  logic [135:0] frame_r;
  logic [7:0] nbits_r;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  // design and host model
  resp_framer resp_framer_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .link_clk(link_clk), .resp_req(resp_req), .resp_kind(resp_kind),
    .resp_index(resp_index), .resp_arg(resp_arg), .card_status(card_status),
    .rca(rca), .volt_acc(volt_acc), .check_pat(check_pat), .cid(cid),
    .csd(csd), .acmd41_req(acmd41_req), .vdd_ok(vdd_ok),
    .init_busy(init_busy), .prog_busy(prog_busy), .resp_ready(resp_ready),
    .card_state(card_state), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
    .dat0_out(dat0_out), .dat0_oe(dat0_oe));
  host_model host_model_inst (.run(run), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
    .dat0_out(dat0_out), .dat0_oe(dat0_oe), .link_clk(link_clk),
    .frame_r(frame_r), .nbits_r(nbits_r), .dat0_line(dat0_line));

  // system clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: run took too long", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [135:0] seen, input logic [135:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // reference crc7, msb first, zero start
  function automatic logic [6:0] crc7(input logic [39:0] h);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = h[i] ^ c[6];
      c = {c[5:0], 1'h0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7

  function automatic logic [135:0] short_f(input logic [5:0] idx,
      input logic [31:0] body, input logic crc_on);
    logic [39:0] h;
    h = {2'h0, idx, body};
    return {88'h0, h, crc_on ? crc7(h) : 7'h7f, 1'h1};
  endfunction : short_f

  task automatic do_reset;
    @(posedge ref_clk);
    run <= 1'h1;
    rst_b <= 1'h0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge ref_clk);
  endtask : do_reset

  // one response request, then wait for the frame to finish
  task automatic send(input resp_kind_t k, input logic [5:0] idx);
    int n;
    @(posedge ref_clk);
    run <= 1'h1;
    n = 0;
    while (resp_ready !== 1'h1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 100) begin
      error_cnt++;
      $display("Error at %0t: block never ready", $time);
      stop_test();
    end
    resp_kind <= k;
    resp_index <= idx;
    resp_req <= 1'h1;
    @(posedge ref_clk);
    resp_req <= 1'h0;
    @(posedge ref_clk);
    chk({135'h0, resp_ready}, 136'h0);
    n = 0;
    while (resp_ready !== 1'h1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 2000) begin
      error_cnt++;
      $display("Error at %0t: frame never ended", $time);
      stop_test();
    end
    run <= 1'h0;
  endtask : send

  task automatic pulse_op(input logic vdd, input logic ib);
    vdd_ok <= vdd;
    init_busy <= ib;
    acmd41_req <= 1'h1;
    @(posedge ref_clk);
    acmd41_req <= 1'h0;
    @(posedge ref_clk);
  endtask : pulse_op

  task automatic t_opcond;
    pulse_op(1'h1, 1'h1);
    chk({134'h0, card_state}, {134'h0, st_idle});
    pulse_op(1'h1, 1'h0);
    chk({134'h0, card_state}, {134'h0, st_ready});
    pulse_op(1'h0, 1'h0);
    chk({134'h0, card_state}, {134'h0, st_ready});
    do_reset();
    pulse_op(1'h0, 1'h1);
    chk({134'h0, card_state}, {134'h0, st_inactive});
    do_reset();
    $display("test opcond done");
  endtask : t_opcond

  task automatic t_normal;
    card_status <= 32'hc0f00a51;
    send(kind_normal, 6'h3f);
    chk(frame_r, short_f(6'h3f, 32'hc0f00a51, 1'h1));
    chk({128'h0, nbits_r}, 136'h30);
    send(kind_normal, 6'h00);
    chk(frame_r, short_f(6'h00, 32'hc0f00a51, 1'h1));
    $display("test normal done");
  endtask : t_normal

  task automatic t_busy;
    card_status <= 32'h00000900;
    send(kind_busy, 6'h07);
    chk(frame_r, short_f(6'h07, 32'h00000900, 1'h1));
    @(posedge ref_clk);
    run <= 1'h1;
    prog_busy <= 1'h1;
    repeat (50) @(posedge ref_clk);
    chk({134'h0, dat0_line, dat0_oe}, 136'h1);
    prog_busy <= 1'h0;
    repeat (50) @(posedge ref_clk);
    chk({134'h0, dat0_line, dat0_oe}, 136'h2);
    run <= 1'h0;
    $display("test busy done");
  endtask : t_busy

  task automatic t_long;
    cid <= CID_V;
    csd <= CSD_V;
    send(kind_long, 6'h09);
    chk(frame_r, {2'h0, 6'h3f, CSD_V, 1'h1});
    chk({128'h0, nbits_r}, 136'h88);
    send(kind_long, 6'h02);
    chk(frame_r, {2'h0, 6'h3f, CID_V, 1'h1});
    send(kind_long, 6'h0a);
    chk(frame_r, {2'h0, 6'h3f, CID_V, 1'h1});
    $display("test long done");
  endtask : t_long

  task automatic t_short_kinds;
    resp_arg <= 32'h80ff8000;
    rca <= 16'hb37d;
    card_status <= ST_V;
    volt_acc <= 4'h1;
    check_pat <= 8'haa;
    send(kind_ocr, 6'h29);
    chk(frame_r, short_f(6'h3f, 32'h80ff8000, 1'h0));
    send(kind_rca, 6'h11);
    chk(frame_r, short_f(6'h03, {16'hb37d, ST_V[23], ST_V[22], ST_V[19],
      ST_V[12:0]}, 1'h1));
    send(kind_ifcond, 6'h00);
    chk(frame_r, short_f(6'h08, {20'h0, 4'h1, 8'haa}, 1'h1));
    $display("test short kinds done");
  endtask : t_short_kinds

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    do_reset();
    t_opcond();
    t_normal();
    t_busy();
    t_long();
    t_short_kinds();
    stop_test();
  end
endmodule : resp_framer_test
